// [design/sse_pkg.sv]
package sse_pkg;

    // ------------------------------------------------------------
    // instruction encodings
    // ------------------------------------------------------------
    localparam int          INSTR_W        = 12;
    localparam logic [5:0]  OPC_SUBTRACT   = 6'h02;
    localparam logic [5:0]  OPC_NIBBLE_EX  = 6'h0E;
    localparam logic [8:0]  OPC_DIR_LOAD   = 9'h000;
    localparam int          OPC_HI         = 11;
    localparam int          OPC6_LO        = 6;
    localparam int          OPC9_LO        = 3;
    localparam int          DEST_BIT       = 5;
    localparam int          FADDR_HI       = 4;
    localparam logic [2:0]  DIR_SEL_FIRST  = 3'h5;
    localparam logic [2:0]  DIR_SEL_LAST   = 3'h7;
    localparam logic        DEST_WORK      = 1'b0;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_WORK      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_DIR5      = 8'h08;
    localparam logic [7:0]  ADDR_DIR6      = 8'h0C;
    localparam logic [7:0]  ADDR_DIR7      = 8'h10;
    localparam logic [7:0]  ADDR_CTRL      = 8'h14;
    localparam logic [7:0]  ADDR_EVENT     = 8'h18;

    // status fields
    localparam int          STAT_CARRY     = 0;
    localparam int          STAT_HALF      = 1;
    localparam int          STAT_ZERO      = 2;

    // reset values
    localparam logic [7:0]  WORK_RST       = 8'h00;
    localparam logic [2:0]  STATUS_RST     = 3'h0;
    localparam logic [7:0]  DIR_RST        = 8'hFF;
    localparam logic        CTRL_EN_RST    = 1'b1;

    // ahb
    localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ     = 2'h3;

endpackage : sse_pkg

// [design/sse_alu.sv]
`timescale 1ns/100ps
`default_nettype none

module sse_alu #(
    parameter int WIDTH = 8
) (
    // operands
    input  wire logic [WIDTH-1:0] opnd_file,
    input  wire logic [WIDTH-1:0] opnd_work,
    // results
    output logic      [WIDTH-1:0] diff,
    output logic      [WIDTH-1:0] swapped,
    output logic                  carry_out,
    output logic                  half_carry_out,
    output logic                  zero_out
);

    logic [WIDTH:0]   full_diff;
    logic [WIDTH/2:0] low_diff;

    // ------------------------------------------------------------
    // subtract, flags
    // ------------------------------------------------------------
    assign full_diff      = {1'b0, opnd_file} - {1'b0, opnd_work};
    assign diff           = full_diff[WIDTH-1:0];
    assign carry_out      = ~full_diff[WIDTH];
    assign low_diff       = {1'b0, opnd_file[WIDTH/2-1:0]} - {1'b0, opnd_work[WIDTH/2-1:0]};
    assign half_carry_out = ~low_diff[WIDTH/2];
    assign zero_out       = (diff == '0);

    // ------------------------------------------------------------
    // nibble exchange
    // ------------------------------------------------------------
    assign swapped        = {opnd_file[WIDTH/2-1:0], opnd_file[WIDTH-1:WIDTH/2]};

endmodule : sse_alu

`default_nettype wire

// [design/sse_exec.sv]
// Contract
// - subtract_acc_from_reg computes file minus working register and writes it to work (d=0) or file (d=1).
// - subtract updates carry, half carry and zero, carry being 1 unless a borrow occurred.
// - nibble_exchange swaps the two nibbles of the file register and leaves every flag alone.
// - the nibble_exchange result goes to the working register for d=0 and to the file register for d=1.
// - port_direction_load copies the working register into direction register 5, 6 or 7, flags untouched.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module sse_exec (
    // clock, reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // instruction in
    input  wire logic        instr_valid,
    input  wire logic [11:0] instr_word,
    output logic             instr_ready,
    // register file
    output logic      [4:0]  file_raddr,
    input  wire logic [7:0]  file_rdata,
    output logic             file_we,
    output logic      [4:0]  file_waddr,
    output logic      [7:0]  file_wdata,
    // core state
    output logic      [7:0]  work_reg,
    output logic             carry_flag,
    output logic             half_carry_flag,
    output logic             zero_flag,
    output logic      [7:0]  port_dir_5,
    output logic      [7:0]  port_dir_6,
    output logic      [7:0]  port_dir_7,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  work_r;
    logic [2:0]  status_r;
    logic [7:0]  dir_r [3];
    logic        ctrl_en_r;
    logic        bad_sel_r;
    logic        file_we_r;
    logic [4:0]  file_waddr_r;
    logic [7:0]  file_wdata_r;
    logic [31:0] hrdata_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic       fire;
    logic       is_sub;
    logic       is_swap;
    logic       is_dir;
    logic       dest_file;
    logic [2:0] dir_sel;
    logic       dir_ok;
    logic [1:0] dir_idx;
    logic [7:0] diff;
    logic [7:0] swapped;
    logic [7:0] result;
    logic       c_new;
    logic       dc_new;
    logic       z_new;

    // no stall source inside: the block takes one word every cycle while enabled
    assign instr_ready = ctrl_en_r;
    assign fire        = instr_valid & ctrl_en_r;
    assign is_sub      = fire & (instr_word[sse_pkg::OPC_HI:sse_pkg::OPC6_LO] == sse_pkg::OPC_SUBTRACT);
    assign is_swap     = fire & (instr_word[sse_pkg::OPC_HI:sse_pkg::OPC6_LO] == sse_pkg::OPC_NIBBLE_EX);
    assign dir_sel     = instr_word[sse_pkg::OPC9_LO-1:0];
    assign dir_ok      = (dir_sel >= sse_pkg::DIR_SEL_FIRST) & (dir_sel <= sse_pkg::DIR_SEL_LAST);
    assign is_dir      = fire & (instr_word[sse_pkg::OPC_HI:sse_pkg::OPC9_LO] == sse_pkg::OPC_DIR_LOAD);
    assign dir_idx     = 2'(dir_sel - sse_pkg::DIR_SEL_FIRST);
    assign dest_file   = instr_word[sse_pkg::DEST_BIT];
    assign file_raddr  = instr_word[sse_pkg::FADDR_HI:0];
    assign result      = is_sub ? diff : swapped;

    sse_alu #(
        .WIDTH (8)
    ) u_alu (
        .opnd_file      (file_rdata),
        .opnd_work      (work_r),
        .diff           (diff),
        .swapped        (swapped),
        .carry_out      (c_new),
        .half_carry_out (dc_new),
        .zero_out       (z_new)
    );

    // ------------------------------------------------------------
    // ahb-lite front end
    // ------------------------------------------------------------
    logic       ahb_go;
    logic       bus_wr;
    logic [7:0] bus_byte;

    // single-cycle slave: never inserts wait states, never errors
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;
    assign ahb_go    = hsel & hready & (htrans == sse_pkg::HTRANS_NONSEQ | htrans == sse_pkg::HTRANS_SEQ);
    assign bus_wr    = wr_pend_r;
    assign bus_byte  = hwdata[7:0];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= ahb_go & hwrite;
            wr_addr_r <= haddr[7:0];
        end
    end

    // read data sampled in the address phase, so it stands in the data phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata_r <= 32'h00000000;
        end else if (ahb_go & ~hwrite) begin
            case (haddr[7:0])
                sse_pkg::ADDR_WORK:   hrdata_r <= {24'h000000, work_r};
                sse_pkg::ADDR_STATUS: hrdata_r <= {29'h00000000, status_r};
                sse_pkg::ADDR_DIR5:   hrdata_r <= {24'h000000, dir_r[0]};
                sse_pkg::ADDR_DIR6:   hrdata_r <= {24'h000000, dir_r[1]};
                sse_pkg::ADDR_DIR7:   hrdata_r <= {24'h000000, dir_r[2]};
                sse_pkg::ADDR_CTRL:   hrdata_r <= {31'h00000000, ctrl_en_r};
                sse_pkg::ADDR_EVENT:  hrdata_r <= {31'h00000000, bad_sel_r};
                default:              hrdata_r <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // working register
    // ------------------------------------------------------------
    // an executing instruction outranks a bus write in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            work_r <= sse_pkg::WORK_RST;
        end else if ((is_sub | is_swap) & (dest_file == sse_pkg::DEST_WORK)) begin
            work_r <= result;
        end else if (bus_wr & (wr_addr_r == sse_pkg::ADDR_WORK)) begin
            work_r <= bus_byte;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_r <= sse_pkg::STATUS_RST;
        end else if (is_sub) begin
            status_r[sse_pkg::STAT_CARRY] <= c_new;
            status_r[sse_pkg::STAT_HALF]  <= dc_new;
            status_r[sse_pkg::STAT_ZERO]  <= z_new;
        end else if (bus_wr & (wr_addr_r == sse_pkg::ADDR_STATUS)) begin
            status_r <= bus_byte[2:0];
        end
    end

    // ------------------------------------------------------------
    // file register write-back
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            file_we_r    <= 1'b0;
            file_waddr_r <= 5'h00;
            file_wdata_r <= 8'h00;
        end else begin
            file_we_r    <= (is_sub | is_swap) & dest_file;
            file_waddr_r <= instr_word[sse_pkg::FADDR_HI:0];
            file_wdata_r <= result;
        end
    end

    // ------------------------------------------------------------
    // port direction registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_r[0] <= sse_pkg::DIR_RST;
            dir_r[1] <= sse_pkg::DIR_RST;
            dir_r[2] <= sse_pkg::DIR_RST;
        end else if (is_dir & dir_ok) begin
            dir_r[dir_idx] <= work_r;
        end
    end

    // ------------------------------------------------------------
    // control and event
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_en_r <= sse_pkg::CTRL_EN_RST;
        end else if (bus_wr & (wr_addr_r == sse_pkg::ADDR_CTRL)) begin
            ctrl_en_r <= bus_byte[0];
        end
    end

    // invalid selector is dropped; sticky flag, write 1 to clear, set wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bad_sel_r <= 1'b0;
        end else if (is_dir & ~dir_ok) begin
            bad_sel_r <= 1'b1;
        end else if (bus_wr & (wr_addr_r == sse_pkg::ADDR_EVENT) & bus_byte[0]) begin
            bad_sel_r <= 1'b0;
        end
    end

    assign file_we         = file_we_r;
    assign file_waddr      = file_waddr_r;
    assign file_wdata      = file_wdata_r;
    assign work_reg        = work_r;
    assign carry_flag      = status_r[sse_pkg::STAT_CARRY];
    assign half_carry_flag = status_r[sse_pkg::STAT_HALF];
    assign zero_flag       = status_r[sse_pkg::STAT_ZERO];
    assign port_dir_5      = dir_r[0];
    assign port_dir_6      = dir_r[1];
    assign port_dir_7      = dir_r[2];

endmodule : sse_exec

`default_nettype wire

// [test/sse_rf_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sse_rf_model (
    // clock, reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // file port
    input  wire logic [4:0] file_raddr,
    output logic      [7:0] file_rdata,
    input  wire logic       file_we,
    input  wire logic [4:0] file_waddr,
    input  wire logic [7:0] file_wdata
);
    logic [7:0] mem [32];
    // read has no latency: the exec block samples it in the take cycle
    assign file_rdata = mem[file_raddr];
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 32; i++) mem[i] <= 8'(i * 29 + 7);
        end else if (file_we) begin
            mem[file_waddr] <= file_wdata;
        end
    end
endmodule : sse_rf_model
`default_nettype wire

// [test/sse_exec_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module sse_exec_chk (
    // clock, reset
    input wire logic        clk,
    input wire logic        rst_n,
    // instruction and file
    input wire logic        instr_valid,
    input wire logic [11:0] instr_word,
    input wire logic        instr_ready,
    input wire logic [4:0]  file_raddr,
    input wire logic [7:0]  file_rdata,
    input wire logic        file_we,
    input wire logic [4:0]  file_waddr,
    input wire logic [7:0]  file_wdata,
    // core state
    input wire logic [7:0]  work_reg,
    input wire logic        carry_flag,
    input wire logic        half_carry_flag,
    input wire logic        zero_flag,
    input wire logic [7:0]  port_dir_5,
    input wire logic [7:0]  port_dir_6,
    input wire logic [7:0]  port_dir_7
);
    logic tk, sub, swp, dl;
    assign tk  = instr_valid && instr_ready;
    assign sub = tk && instr_word[11:6] == sse_pkg::OPC_SUBTRACT;
    assign swp = tk && instr_word[11:6] == sse_pkg::OPC_NIBBLE_EX;
    assign dl  = tk && instr_word[11:3] == sse_pkg::OPC_DIR_LOAD;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_RADDR: assert property (file_raddr == instr_word[4:0])
        else $error("file read address wrong");
    AST_SUB_FILE: assert property (sub && instr_word[5] |=> file_we &&
        file_waddr == $past(file_raddr) && file_wdata == $past(file_rdata) - $past(work_reg))
        else $error("subtract to file wrong");
    AST_SUB_WORK: assert property (sub && !instr_word[5] |=> !file_we &&
        work_reg == $past(file_rdata) - $past(work_reg)) else $error("subtract to work wrong");
    AST_SUB_FLAGS: assert property (sub |=>
        carry_flag == ($past(file_rdata) >= $past(work_reg)) &&
        zero_flag == ($past(file_rdata) == $past(work_reg))) else $error("carry or zero wrong");
    AST_HALF: assert property (sub |=> half_carry_flag ==
        (($past(file_rdata) & 8'h0F) >= ($past(work_reg) & 8'h0F))) else $error("half carry wrong");
    AST_SWAP_FILE: assert property (swp && instr_word[5] |=> file_we &&
        file_wdata == (($past(file_rdata) << 4) | ($past(file_rdata) >> 4)))
        else $error("exchange to file wrong");
    AST_SWAP_WORK: assert property (swp && !instr_word[5] |=> !file_we &&
        work_reg == (($past(file_rdata) << 4) | ($past(file_rdata) >> 4)) &&
        $stable(carry_flag) && $stable(half_carry_flag) && $stable(zero_flag))
        else $error("exchange to work wrong");
    AST_DIR6: assert property (dl && instr_word[2:0] == 3'h6 |=>
        port_dir_6 == $past(work_reg) && $stable(port_dir_5) && $stable(port_dir_7) &&
        $stable(carry_flag) && $stable(zero_flag)) else $error("direction load wrong");
    AST_DIR_BAD: assert property (dl && instr_word[2:0] < sse_pkg::DIR_SEL_FIRST |=>
        $stable(port_dir_5) && $stable(port_dir_6) && $stable(port_dir_7) && !file_we)
        else $error("bad selector changed state");
    AST_IDLE: assert property (instr_valid && !instr_ready |=>
        $stable(work_reg) && !file_we) else $error("refused instruction acted");
endmodule : sse_exec_chk
bind sse_exec sse_exec_chk u_chk (.clk, .rst_n, .instr_valid, .instr_word, .instr_ready,
    .file_raddr, .file_rdata, .file_we, .file_waddr, .file_wdata, .work_reg, .carry_flag,
    .half_carry_flag, .zero_flag, .port_dir_5, .port_dir_6, .port_dir_7);
`default_nettype wire

// [test/sse_exec_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module sse_exec_tb_top;
    logic        clk, rst_n, iv, hsel, hwrite, rdph, ev, en, d;
    logic [11:0] iw;
    logic [31:0] haddr, hwdata, rs, k, q[$];
    logic [1:0]  htrans;
    logic [2:0]  hsize, flg, sel;
    logic [4:0]  fa;
    logic [7:0]  w, f, r, shd [32], dir [8];
    int          mismatches = 0, cmp_count = 0, cyc = 0;
    wire logic        fwe, hro, hrs;
    wire logic [4:0]  fra, fwa;
    wire logic [7:0]  frd, fwd;
    wire logic [31:0] hrdata;
    sse_exec dut (.clk, .rst_n, .instr_valid(iv), .instr_word(iw), .instr_ready(),
        .file_raddr(fra), .file_rdata(frd), .file_we(fwe), .file_waddr(fwa), .file_wdata(fwd),
        .work_reg(), .carry_flag(), .half_carry_flag(), .zero_flag(), .port_dir_5(),
        .port_dir_6(), .port_dir_7(), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hro), .hreadyout(hro), .hresp(hrs), .hrdata);
    sse_rf_model u_rf (.clk, .rst_n, .file_raddr(fra), .file_rdata(frd), .file_we(fwe),
        .file_waddr(fwa), .file_wdata(fwd));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : xs
    function automatic logic [31:0] ex(input logic [7:0] a);
        case (a)
            sse_pkg::ADDR_WORK:   return {24'h0, w};
            sse_pkg::ADDR_STATUS: return {29'h0, flg};
            sse_pkg::ADDR_DIR5:   return {24'h0, dir[5]};
            sse_pkg::ADDR_DIR6:   return {24'h0, dir[6]};
            sse_pkg::ADDR_DIR7:   return {24'h0, dir[7]};
            sse_pkg::ADDR_CTRL:   return {31'h0, en};
            sse_pkg::ADDR_EVENT:  return {31'h0, ev};
            default:              return 32'h0;
        endcase
    endfunction : ex
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report();
        if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    // reads carry their expected value in dv
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] dv);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= sse_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge clk);
        while (hro !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dv;
        rdph <= !wr;
        if (!wr) q.push_back(dv);
        @(posedge clk);
        while (hro !== 1'b1) @(posedge clk);
        rdph <= 1'b0;
    endtask : ahb
    task automatic ins(input logic [11:0] wd, input logic we);
        @(posedge clk);
        iv <= 1'b1;
        iw <= wd;
        if (we) q.push_back({19'h0, fa, r});
        @(posedge clk);
        iv <= 1'b0;
    endtask : ins
    task automatic read_all();
        for (int a = 0; a < 32; a += 4) ahb(1'b0, 8'(a), ex(8'(a)));
    endtask : read_all
    // ------------------------------------------------------------
    // monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst_n && fwe === 1'b1)
            chk({19'h0, fwa, fwd}, q.size() ? q.pop_front() : 32'hFFFFFFFF);
        if (rst_n && rdph && hro === 1'b1)
            chk(hrdata, q.size() ? q.pop_front() : 32'hFFFFFFFF);
        if (rst_n && rdph && hro === 1'b1)
            chk({31'h0, hrs}, 32'h0);
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, iv, iw, hsel, haddr, htrans, hwrite, hwdata, rdph, w, flg, ev} = '0;
        hsize = 3'h2;
        rs = 32'h9FEB;
        en = 1'b1;
        for (int i = 0; i < 32; i++) shd[i] = 8'(i * 29 + 7);
        for (int i = 0; i < 8; i++) dir[i] = 8'hFF;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        ahb(1'b1, sse_pkg::ADDR_DIR5, 32'h12);
        read_all();
        for (int n = 0; n < 80; n++) begin
            w = 8'(xs());
            ahb(1'b1, sse_pkg::ADDR_WORK, {24'h0, w});
            k = xs();
            fa = k[12:8];
            d = k[13];
            sel = k[18:16];
            f = shd[fa];
            if (k[1:0] == 2'h0) begin
                r = f - w;
                flg = {r == 8'h00, f[3:0] >= w[3:0], f >= w};
                ins({6'h02, d, fa}, d);
            end else if (k[1:0] == 2'h1) begin
                r = {f[3:0], f[7:4]};
                ins({6'h0E, d, fa}, d);
            end else begin
                ins({9'h000, sel}, 1'b0);
                if (sel >= 3'h5) dir[sel] = w;
                else ev = 1'b1;
            end
            if (k[1] == 1'b0 && d) shd[fa] = r;
            else if (k[1] == 1'b0) w = r;
            read_all();
            if (ev) ahb(1'b1, sse_pkg::ADDR_EVENT, 32'h1);
            ev = 1'b0;
        end
        // status is software-writable too
        ahb(1'b1, sse_pkg::ADDR_STATUS, 32'h5);
        flg = 3'h5;
        // disabled core must ignore instructions
        ahb(1'b1, sse_pkg::ADDR_CTRL, 32'h0);
        en = 1'b0;
        ins(12'h0A3, 1'b0);
        read_all();
        ahb(1'b1, sse_pkg::ADDR_CTRL, 32'h1);
        en = 1'b1;
        read_all();
        // mid-run reset: every register back to its reset value
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        {w, flg} = '0;
        for (int i = 5; i < 8; i++) dir[i] = 8'hFF;
        read_all();
        // let the monitor take the last read before the queue is judged
        repeat (2) @(posedge clk);
        chk(q.size(), 32'h0);
        final_report();
    end
endmodule : sse_exec_tb_top
`default_nettype wire
